// ### rtl/ocd_output_channel_divider.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The divider output stays low for the low-count field plus one distribution cycles, reset value zero.
// - The divider output stays high for the high-count field plus one distribution cycles, reset value zero.
// - With bypass set the divider idles and the distribution clock passes straight to its output.
// - With sync-exempt clear the divider obeys chip-level sync, with it set the divider ignores sync.
// - The force-level bit parks the output high or low, only while sync-exempt is set and bypass is clear.
// - The start-level bit chooses whether division starts from a high or a low output.
// - A 4-bit phase field delays the start of division by that many distribution cycles.
// - Pair C takes the divider, or with direct-route set the VCO on select 10b, the external clock on 00b, else the divider.
// - Pair B direct-route bit 1 behaves the same way over the second channel's divider output.
// - Duty-cycle correction is engaged while its disable bit and bypass are both clear, and skipped while either is set.
// - Source select is VCO-versus-external in bit 1 and VCO divider bypass in bit 0, the two never both set.
// - Soft sync, opposite in polarity to the sync pin, holds channels static while high and its fall starts them.
module ocd_output_channel_divider (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ocd_pkg::ADDR_W-1:0] paddr,
    input wire logic [ocd_pkg::DATA_W-1:0] pwdata,
    output logic [ocd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources, asynchronous pins
    input wire logic dist_clk,
    input wire logic vco_clk,
    input wire logic ext_clk,
    // Sync controls and source select
    input wire logic sync_pin_n,
    input wire logic soft_sync,
    input wire logic [1:0] source_sel,
    // Second channel divider from the neighbouring block
    input wire logic ch1_div_out,
    // Output pairs
    output logic pair_b_output_p,
    output logic pair_b_output_n,
    output logic pair_c_output_p,
    output logic pair_c_output_n
);
    import ocd_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SY_N-1:0] sy1_q;
    logic [SY_N-1:0] sy2_q;
    logic dist_prev_q;
    logic hold_prev_q;
    logic dist_lvl;
    logic dist_tick;
    logic sync_hold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {sync_pin_n, ext_clk, vco_clk, dist_clk};
            sy2_q <= sy1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dist_prev_q <= 1'b0;
            hold_prev_q <= 1'b1;
        end else begin
            dist_prev_q <= dist_lvl;
            hold_prev_q <= sync_hold;
        end
    end

    // Divider counts on each rising edge of the distribution clock; sources must run below pclk/2
    assign dist_lvl = sy2_q[SY_DIST];
    assign dist_tick = dist_lvl & ~dist_prev_q;
    // Soft sync high or pin low holds the channels
    assign sync_hold = soft_sync | ~sy2_q[SY_PIN];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] ch1_routing_q;
    logic [REG_W-1:0] ch2_counts_q;
    logic [REG_W-1:0] ch2_control_q;
    logic [1:0] ch2_routing_q;
    logic [REG_W-1:0] status_q;
    logic [REG_W-1:0] status_d;

    logic [IDX_W-1:0] idx;
    logic hit_r1;
    logic hit_c;
    logic hit_k;
    logic hit_r2;
    logic hit_st;
    logic hit_any;
    logic setup_ph;
    logic wr_en;

    assign idx = paddr[ADDR_W-1:ADDR_W-IDX_W];
    assign hit_r1 = (idx == IDX_CH1_ROUTING);
    assign hit_c = (idx == IDX_CH2_COUNTS);
    assign hit_k = (idx == IDX_CH2_CONTROL);
    assign hit_r2 = (idx == IDX_CH2_ROUTING);
    assign hit_st = (idx == IDX_CH2_STATUS);
    assign hit_any = hit_r1 | hit_c | hit_k | hit_r2 | hit_st;
    assign setup_ph = psel & ~penable;
    // Write lands on the access edge that also sees pready
    assign wr_en = psel & penable & pready & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch1_routing_q <= RST_ROUTING;
            ch2_counts_q <= RST_COUNTS;
            ch2_control_q <= RST_CONTROL;
            ch2_routing_q <= RST_ROUTING;
        end else if (wr_en) begin
            if (hit_r1) begin
                ch1_routing_q <= pwdata[1:0];
            end
            if (hit_c) begin
                ch2_counts_q <= pwdata[REG_W-1:0];
            end
            if (hit_k) begin
                ch2_control_q <= pwdata[REG_W-1:0];
            end
            if (hit_r2) begin
                ch2_routing_q <= pwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    logic [REG_W-1:0] rd_mux;

    // Unused upper bits of routing registers read as zero
    assign rd_mux = hit_r1 ? {6'h00, ch1_routing_q} :
                    hit_c ? ch2_counts_q :
                    hit_k ? ch2_control_q :
                    hit_r2 ? {6'h00, ch2_routing_q} :
                    hit_st ? status_q : 8'h00;

    // One wait-free access phase: pready rises in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~hit_any;
            if (setup_ph & ~pwrite) begin
                prdata <= {24'h000000, rd_mux};
            end else if (setup_ph) begin
                prdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Third channel divider
    // ------------------------------------------------------------
    ocd_div_cfg_s cfg;
    logic div_out;
    ocd_state_e div_state;

    assign cfg.bypass = ch2_control_q[BIT_BYPASS];
    assign cfg.nosync = ch2_control_q[BIT_NOSYNC];
    assign cfg.force_hi = ch2_control_q[BIT_FORCE];
    assign cfg.start_hi = ch2_control_q[BIT_START];
    assign cfg.phase = ch2_control_q[PHASE_LSB +: CNT_W];
    assign cfg.low_cnt = ch2_counts_q[LOW_LSB +: CNT_W];
    assign cfg.high_cnt = ch2_counts_q[HIGH_LSB +: CNT_W];
    assign cfg.duty_correction_disable = ch2_routing_q[BIT_DCC_OFF];

    ocd_chan_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(dist_tick),
        .src_lvl(dist_lvl),
        .cfg(cfg),
        .hold(sync_hold),
        .out_q(div_out),
        .state_q(div_state)
    );

    // ------------------------------------------------------------
    // Direct routing to the output pairs
    // ------------------------------------------------------------
    logic src_vco;
    logic src_ext;
    logic pair_b_d;
    logic pair_c_d;

    // The illegal select 11b never routes a raw source
    assign src_vco = (source_sel == SRC_VCO_DIRECT);
    assign src_ext = (source_sel == SRC_EXT_DIRECT);

    assign pair_c_d = (ch2_routing_q[BIT_DIRECT] & src_vco) ? sy2_q[SY_VCO] :
                      (ch2_routing_q[BIT_DIRECT] & src_ext) ? sy2_q[SY_EXT] :
                      div_out;
    assign pair_b_d = (ch1_routing_q[BIT_DIRECT] & src_vco) ? sy2_q[SY_VCO] :
                      (ch1_routing_q[BIT_DIRECT] & src_ext) ? sy2_q[SY_EXT] :
                      ch1_div_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_b_output_p <= 1'b0;
            pair_b_output_n <= 1'b1;
            pair_c_output_p <= 1'b0;
            pair_c_output_n <= 1'b1;
        end else begin
            pair_b_output_p <= pair_b_d;
            pair_b_output_n <= ~pair_b_d;
            pair_c_output_p <= pair_c_d;
            pair_c_output_n <= ~pair_c_d;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    // Correction works below one distribution cycle, so here it only shows as engaged
    always_comb begin
        status_d = '0;
        status_d[ST_BIT_OUT] = div_out;
        status_d[ST_BIT_DCC] = ~cfg.duty_correction_disable & ~cfg.bypass;
        status_d[ST_BIT_HOLD] = sync_hold & ~cfg.nosync;
        status_d[ST_BIT_RUN] = (div_state == ST_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // Sync release is seen here for the channel one neighbour too
    logic sync_release_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_release_q <= 1'b0;
        end else begin
            sync_release_q <= hold_prev_q & ~sync_hold;
        end
    end

endmodule
`default_nettype wire

// ### rtl/ocd_pkg.sv
package ocd_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    localparam int REG_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CH1_ROUTING = 10'h195;
    localparam logic [IDX_W-1:0] IDX_CH2_COUNTS = 10'h196;
    localparam logic [IDX_W-1:0] IDX_CH2_CONTROL = 10'h197;
    localparam logic [IDX_W-1:0] IDX_CH2_ROUTING = 10'h198;
    localparam logic [IDX_W-1:0] IDX_CH2_STATUS = 10'h199;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam int LOW_LSB = 4;
    localparam int HIGH_LSB = 0;
    localparam int BIT_BYPASS = 7;
    localparam int BIT_NOSYNC = 6;
    localparam int BIT_FORCE = 5;
    localparam int BIT_START = 4;
    localparam int PHASE_LSB = 0;
    localparam int BIT_DIRECT = 1;
    localparam int BIT_DCC_OFF = 0;
    localparam int ST_BIT_OUT = 0;
    localparam int ST_BIT_DCC = 1;
    localparam int ST_BIT_HOLD = 2;
    localparam int ST_BIT_RUN = 3;

    // ------------------------------------------------------------
    // Reset values and source-select codes
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_COUNTS = 8'h00;
    localparam logic [REG_W-1:0] RST_CONTROL = 8'h00;
    localparam logic [1:0] RST_ROUTING = 2'h0;
    localparam logic [1:0] SRC_VCO_DIRECT = 2'h2;
    localparam logic [1:0] SRC_EXT_DIRECT = 2'h0;

    // Synchroniser lanes
    localparam int SY_N = 4;
    localparam int SY_DIST = 0;
    localparam int SY_VCO = 1;
    localparam int SY_EXT = 2;
    localparam int SY_PIN = 3;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_PHASE = 2'b01,
        ST_RUN = 2'b10
    } ocd_state_e;

    typedef struct packed {
        logic bypass;
        logic nosync;
        logic force_hi;
        logic start_hi;
        logic [CNT_W-1:0] phase;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic duty_correction_disable;
    } ocd_div_cfg_s;

endpackage

// ### rtl/ocd_chan_div.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_chan_div (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Distribution clock as enable pulse and level
    input wire logic tick,
    input wire logic src_lvl,
    // Configuration and sync
    input wire ocd_pkg::ocd_div_cfg_s cfg,
    input wire logic hold,
    // Result
    output logic out_q,
    output ocd_pkg::ocd_state_e state_q
);
    import ocd_pkg::*;

    logic out_d;
    ocd_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;
    logic at_limit;
    logic phase_last;

    assign limit = out_q ? cfg.high_cnt : cfg.low_cnt;
    assign at_limit = (cnt_q == limit);
    assign phase_last = (cnt_q == cfg.phase - 1'b1);

    always_comb begin
        out_d = out_q;
        state_d = state_q;
        cnt_d = cnt_q;
        if (cfg.bypass) begin
            // Divider idle, source passed straight through
            out_d = src_lvl;
            state_d = ST_HOLD;
            cnt_d = '0;
        end else if (cfg.nosync) begin
            // Sync ignored, output parked at the forced level
            out_d = cfg.force_hi;
            state_d = ST_HOLD;
            cnt_d = '0;
        end else if (hold) begin
            // Static state while sync is asserted
            out_d = cfg.start_hi;
            state_d = ST_HOLD;
            cnt_d = '0;
        end else begin
            case (state_q)
                ST_HOLD: begin
                    // Release of sync starts division
                    out_d = cfg.start_hi;
                    cnt_d = '0;
                    state_d = (cfg.phase == '0) ? ST_RUN : ST_PHASE;
                end
                ST_PHASE: begin
                    // Coarse delay in distribution cycles
                    if (tick) begin
                        if (phase_last) begin
                            cnt_d = '0;
                            state_d = ST_RUN;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    // Low for low+1 cycles, high for high+1
                    if (tick) begin
                        if (at_limit) begin
                            out_d = ~out_q;
                            cnt_d = '0;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = ST_HOLD;
                    cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
            state_q <= ST_HOLD;
            cnt_q <= '0;
        end else begin
            out_q <= out_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

endmodule
`default_nettype wire

// ### testbench/ocd_output_channel_divider_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_output_channel_divider_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ocd_pkg::ADDR_W-1:0] paddr,
    input wire logic [ocd_pkg::DATA_W-1:0] pwdata,
    input wire logic [ocd_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sync and pairs
    input wire logic soft_sync,
    input wire logic pair_b_output_p,
    input wire logic pair_b_output_n,
    input wire logic pair_c_output_p,
    input wire logic pair_c_output_n
);
    import ocd_pkg::*;
    // ----------------------------------------
    // Shadow of control bits, seen from the bus
    // ----------------------------------------
    logic [7:0] ctl_q;
    logic dirc_q;
    wire [IDX_W-1:0] idx = paddr[11:2];
    wire unmapped = (idx < IDX_CH1_ROUTING) || (idx > IDX_CH2_STATUS);
    wire wr = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 8'h00;
            dirc_q <= 1'b0;
        end else begin
            if (wr && idx == IDX_CH2_CONTROL) ctl_q <= pwdata[7:0];
            if (wr && idx == IDX_CH2_ROUTING) dirc_q <= pwdata[BIT_DIRECT];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // Control must be steady, the output lags a write by a few cycles
    sequence s_park;
        ctl_q[BIT_NOSYNC] && !ctl_q[BIT_BYPASS] && !dirc_q && $stable(ctl_q);
    endsequence
    sequence s_held(logic [7:0] c);
        soft_sync && ctl_q == c && !dirc_q;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready && psel && penable)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
    a_error_decode: assert property (s_setup |=> pslverr == $past(unmapped)) else $error("pslverr wrong");
    a_error_data_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data");
    a_upper_read_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
    a_pair_b_compl: assert property (pair_b_output_n == !pair_b_output_p) else $error("pair b");
    a_pair_c_compl: assert property (pair_c_output_n == !pair_c_output_p) else $error("pair c");
    a_hold_start_low: assert property (s_held(8'h00)[*8] |-> !pair_c_output_p)
        else $error("held output not low");
    a_hold_start_high: assert property (s_held(8'h10)[*8] |-> pair_c_output_p)
        else $error("held output not high");
    a_force_park: assert property (s_park[*8] |-> pair_c_output_p == ctl_q[BIT_FORCE])
        else $error("force level");
endmodule
bind ocd_output_channel_divider ocd_output_channel_divider_properties chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_sync(soft_sync), .pair_b_output_p(pair_b_output_p), .pair_b_output_n(pair_b_output_n),
    .pair_c_output_p(pair_c_output_p), .pair_c_output_n(pair_c_output_n));
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ocd_pkg::*;
    typedef struct {
        logic [7:0] cnt;
        int hi;
        int lo;
    } ocd_row_s;
    // Distribution clock toggles every 4 pclk, so one tick is 8 pclk
    localparam int TK = 8;
    ocd_row_s rows [4] = '{'{8'h00, 8, 8}, '{8'h11, 16, 16}, '{8'hf0, 8, 128}, '{8'h2c, 104, 24}};
    logic [1:0] sels [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, pb_p, pb_n, pc_p, pc_n;
    logic [2:0] dcnt = 3'h0;
    logic vco_clk = 1'b0;
    logic ext_clk = 1'b0;
    logic sync_pin_n = 1'b1;
    logic soft_sync = 1'b0;
    logic [1:0] source_sel = 2'b00;
    logic ch1_div_out = 1'b0;
    wire dist_clk = dcnt[2];
    int bad_count = 0;
    int comparisons = 0;
    always #50 pclk = ~pclk;
    always @(posedge pclk) dcnt <= dcnt + 3'h1;
    ocd_output_channel_divider dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dist_clk(dist_clk), .vco_clk(vco_clk), .ext_clk(ext_clk), .sync_pin_n(sync_pin_n),
        .soft_sync(soft_sync), .source_sel(source_sel), .ch1_div_out(ch1_div_out),
        .pair_b_output_p(pb_p), .pair_b_output_n(pb_n), .pair_c_output_p(pc_p), .pair_c_output_n(pc_n));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check(32'(pready), 32'h1, "pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic er;
        apb(1'b1, idx, wd, rd, er);
    endtask
    task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic eexp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, idx, 8'h00, rd, er);
        check(rd, exp, "read data");
        check(32'(er), 32'(eexp), "slave error");
    endtask
    task automatic lvl(input int n, input logic exp, input string what);
        repeat (n) @(posedge pclk);
        check(32'(pc_p), 32'(exp), what);
    endtask
    task automatic meas(output int hi, output int lo);
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        while (pc_p !== 1'b0 && n < 400) begin @(posedge pclk); n++; end
        while (pc_p !== 1'b1 && n < 400) begin @(posedge pclk); n++; end
        while (pc_p === 1'b1 && n < 400) begin @(posedge pclk); n++; hi++; end
        while (pc_p === 1'b0 && n < 400) begin @(posedge pclk); n++; lo++; end
    endtask
    task automatic first(input logic [3:0] p, output int t);
        wr(IDX_CH2_CONTROL, {4'h0, p});
        soft_sync <= 1'b1;
        repeat (8) @(posedge pclk);
        while (dcnt != 3'h0) @(posedge pclk);
        soft_sync <= 1'b0;
        t = 0;
        while (pc_p !== 1'b1 && t < 400) begin @(posedge pclk); t++; end
    endtask
    task automatic conclude;
        $display("Totals: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        #3000000;
        bad_count++;
        conclude;
    end
    initial begin
        int hi, lo, t0, t5, e;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rdc(10'(IDX_CH1_ROUTING + i), 32'h0, 1'b0);
        rdc(10'h1a0, 32'h0, 1'b1);
        wr(IDX_CH2_CONTROL, 8'hd5);
        rdc(IDX_CH2_CONTROL, 32'hd5, 1'b0);
        wr(IDX_CH2_CONTROL, 8'h00);
        $display("registers done");
        foreach (rows[i]) begin
            wr(IDX_CH2_COUNTS, rows[i].cnt);
            meas(hi, lo);
            meas(hi, lo);
            check(hi, rows[i].hi, "high time");
            check(lo, rows[i].lo, "low time");
        end
        $display("ratios done");
        soft_sync <= 1'b1;
        wr(IDX_CH2_CONTROL, 8'h10);
        lvl(8, 1'b1, "start high");
        wr(IDX_CH2_CONTROL, 8'h00);
        lvl(8, 1'b0, "start low");
        rdc(IDX_CH2_STATUS, 32'h6, 1'b0);
        wr(IDX_CH2_ROUTING, 8'h01);
        rdc(IDX_CH2_STATUS, 32'h4, 1'b0);
        wr(IDX_CH2_ROUTING, 8'h00);
        wr(IDX_CH2_COUNTS, 8'h11);
        first(4'h0, t0);
        first(4'h5, t5);
        check(t5 - t0, 5 * TK, "phase delay");
        $display("sync and phase done");
        sync_pin_n <= 1'b0;
        wr(IDX_CH2_CONTROL, 8'h00);
        // Pin passes two flops, then divider and pair flops, before the hold shows
        repeat (2) @(posedge pclk);
        hi = 0;
        repeat (40) begin @(posedge pclk); if (pc_p !== 1'b0) hi++; end
        check(hi, 0, "pin hold");
        wr(IDX_CH2_CONTROL, 8'h60);
        lvl(8, 1'b1, "exempt force high");
        wr(IDX_CH2_CONTROL, 8'h40);
        lvl(8, 1'b0, "exempt force low");
        sync_pin_n <= 1'b1;
        wr(IDX_CH2_CONTROL, 8'he0);
        meas(hi, lo);
        meas(hi, lo);
        check(hi, TK / 2, "bypass high");
        check(lo, TK / 2, "bypass low");
        wr(IDX_CH2_CONTROL, 8'h00);
        $display("force and bypass done");
        soft_sync <= 1'b1;
        ch1_div_out <= 1'b1;
        wr(IDX_CH2_ROUTING, 8'h02);
        wr(IDX_CH1_ROUTING, 8'h02);
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 2; v++) begin
                source_sel <= sels[s];
                vco_clk <= v[0];
                ext_clk <= !v[0];
                e = (s == 0) ? v : (s == 1) ? 1 - v : 0;
                lvl(8, e[0], "pair c route");
                e = (s >= 2) ? 1 : e;
                check(32'(pb_p), 32'(e[0]), "pair b route");
            end
        end
        $display("routing done");
        // Mid-run reset with both pairs routed direct and counts non-zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(32'({pb_p, pb_n, pc_p, pc_n}), 32'h5, "reset pairs");
        check({prdata[30:0], pready}, 32'h0, "reset bus");
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rdc(10'(IDX_CH1_ROUTING + i), 32'h0, 1'b0);
        $display("reset done");
        conclude;
    end
endmodule
`default_nettype wire
